// *** hdl/fmtx_top.sv ***
// Transmit framer: preamble, delimiter, header, padded data, CRC, Manchester.
// Assumes the controller streams destination, source, length and payload
// bytes in order, and keeps the buffer fed once a frame has started.
`timescale 1ns/10ps
module fmtx_top
    import fmtx_pkg::*;
#(
    parameter int unsigned JABBER_CYCLES = FMTX_JABBER_CYCLES,
    parameter int unsigned HOLD_CYCLES = FMTX_HOLD_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Byte feed from the network controller
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    // Encoded line toward the transceiver
    output fmtx_line_type line_out,
    // Status toward the controller
    output fmtx_stat_type status
);

    localparam logic [26:0] JAB_LAST = 27'(JABBER_CYCLES - 1);
    localparam logic [26:0] HOLD_LAST = 27'(HOLD_CYCLES - 1);

    fmtx_top_state_type s, n;
    logic buf_valid;
    logic [7:0] buf_data;
    logic pop;
    logic crc_init;
    logic crc_step;
    logic crc_drain;
    logic crc_bit;
    logic half_tick;
    logic cell_end;
    logic bit_now;
    logic fetch;

    // Two entries absorb the fetch jitter; a full buffer holds the controller off, so no byte is lost
    fmtx_buf2 u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(buf_valid),
        .out_ready(pop),
        .out_data(buf_data)
    );

    fmtx_crc32 u_crc (
        .clk(clk),
        .rst(rst),
        .init(crc_init),
        .step(crc_step),
        .bit_in(bit_now),
        .drain(crc_drain),
        .crc_bit(crc_bit)
    );

    // Half-cell divider marks mid-cell and cell end
    assign half_tick = (s.st != FMTX_IDLE) && (s.div == FMTX_HALF_LAST);
    assign cell_end = half_tick && s.ph;
    assign line_out = s.line;
    assign status = s.stat;

    // Bit presently on the line, by frame section
    always_comb begin
        case (s.st)
            FMTX_PRE: bit_now = ~s.cnt[0];
            FMTX_SFD: bit_now = 1'b1;
            FMTX_HDR, FMTX_DATA, FMTX_PAD: bit_now = s.byte_v[s.bidx];
            FMTX_CRC: bit_now = crc_bit;
            default: bit_now = 1'b0;
        endcase
    end

    // Frame sequencer, watchdog and line register
    always_comb begin
        n = s;
        pop = 1'b0;
        fetch = 1'b0;
        crc_init = 1'b0;
        crc_step = 1'b0;
        crc_drain = 1'b0;
        n.stat.underrun = 1'b0;
        n.stat.frame_done = 1'b0;

        // Watchdog runs while sending, then times the hold-off
        if (s.st != FMTX_IDLE) begin
            if (s.jab) begin
                n.jcnt = '0;
            end else if (s.jcnt == JAB_LAST) begin
                n.jab = 1'b1;
                n.jcnt = '0;
            end else begin
                n.jcnt = s.jcnt + 27'h0000001;
            end
        end else if (s.jab) begin
            if (s.jcnt == HOLD_LAST) begin
                n.jab = 1'b0;
                n.jcnt = '0;
            end else begin
                n.jcnt = s.jcnt + 27'h0000001;
            end
        end else begin
            n.jcnt = '0;
        end

        if (s.st == FMTX_IDLE) begin
            // Start only with a byte in hand and the driver allowed
            if (buf_valid && !s.jab) begin
                n.st = FMTX_PRE;
                n.div = '0;
                n.ph = 1'b0;
                n.cnt = '0;
                crc_init = 1'b1;
            end
        end else begin
            if (half_tick) begin
                n.div = '0;
                n.ph = ~s.ph;
            end else begin
                n.div = s.div + 4'h1;
            end
        end

        if (cell_end) begin
            case (s.st)
                FMTX_PRE: begin
                    if (s.cnt == FMTX_PRE_LAST) begin
                        n.st = FMTX_SFD;
                        n.cnt = '0;
                    end else begin
                        n.cnt = s.cnt + 6'h01;
                    end
                end
                FMTX_SFD: begin
                    if (s.cnt == FMTX_SFD_LAST) begin
                        n.st = FMTX_HDR;
                        n.hidx = '0;
                        fetch = 1'b1;
                    end else begin
                        n.cnt = s.cnt + 6'h01;
                    end
                end
                FMTX_HDR: begin
                    crc_step = 1'b1;
                    if (s.bidx != FMTX_BIT_LAST) begin
                        n.bidx = s.bidx + 3'h1;
                    end else if (s.hidx == FMTX_LEN_HI_IDX) begin
                        n.len_hi = s.byte_v;
                        n.hidx = s.hidx + 4'h1;
                        fetch = 1'b1;
                    end else if (s.hidx == FMTX_LEN_LO_IDX) begin
                        // Length is sent as given; padding never alters it
                        n.len = 11'({s.len_hi, s.byte_v});
                        n.dcnt = '0;
                        if ({s.len_hi, s.byte_v} == 16'h0000) begin
                            n.st = FMTX_PAD;
                            n.byte_v = FMTX_PAD_BYTE;
                            n.bidx = '0;
                        end else begin
                            n.st = FMTX_DATA;
                            fetch = 1'b1;
                        end
                    end else begin
                        n.hidx = s.hidx + 4'h1;
                        fetch = 1'b1;
                    end
                end
                FMTX_DATA: begin
                    crc_step = 1'b1;
                    if (s.bidx != FMTX_BIT_LAST) begin
                        n.bidx = s.bidx + 3'h1;
                    end else begin
                        n.dcnt = s.dcnt + 11'h001;
                        if (s.dcnt + 11'h001 == s.len) begin
                            if (s.len < FMTX_DATA_MIN) begin
                                n.st = FMTX_PAD;
                                n.byte_v = FMTX_PAD_BYTE;
                                n.bidx = '0;
                            end else begin
                                n.st = FMTX_CRC;
                                n.cnt = '0;
                            end
                        end else begin
                            fetch = 1'b1;
                        end
                    end
                end
                FMTX_PAD: begin
                    crc_step = 1'b1;
                    if (s.bidx != FMTX_BIT_LAST) begin
                        n.bidx = s.bidx + 3'h1;
                    end else begin
                        n.dcnt = s.dcnt + 11'h001;
                        n.bidx = '0;
                        if (s.dcnt + 11'h001 == FMTX_DATA_MIN) begin
                            n.st = FMTX_CRC;
                            n.cnt = '0;
                        end
                    end
                end
                FMTX_CRC: begin
                    crc_drain = 1'b1;
                    if (s.cnt == FMTX_CRC_LAST) begin
                        n.st = FMTX_IDLE;
                        n.stat.frame_done = 1'b1;
                    end else begin
                        n.cnt = s.cnt + 6'h01;
                    end
                end
                default: begin
                    n.st = FMTX_IDLE;
                end
            endcase
        end

        // The line cannot pause, so an empty buffer aborts the frame
        if (fetch) begin
            if (buf_valid) begin
                pop = 1'b1;
                n.byte_v = buf_data;
                n.bidx = '0;
            end else begin
                n.st = FMTX_IDLE;
                n.stat.underrun = 1'b1;
            end
        end

        // One cycle of latency after the sequencer; jabber kills the driver
        n.line.en = (s.st != FMTX_IDLE) && !s.jab;
        n.line.data = n.line.en && (s.ph ? bit_now : ~bit_now);
        n.stat.collision = s.jab;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= FMTX_TOP_RST;
        end else begin
            s <= n;
        end
    end

    // Idle line stays low
    a_idle_line_low: assert property (@(posedge clk) disable iff (rst)
        !line_out.en |-> !line_out.data)
        else $error("line toggles while idle");

    // Mid-cell transition
    a_mid_cell_edge: assert property (@(posedge clk) disable iff (rst)
        (half_tick && !s.ph) |-> ##2 (!line_out.en || line_out.data != $past(line_out.data)))
        else $error("missing mid-cell transition");

    // Delimiter: low then high within each cell
    a_sfd_halves: assert property (@(posedge clk) disable iff (rst)
        (s.st == FMTX_SFD) |=> (!line_out.en || line_out.data == $past(s.ph)))
        else $error("delimiter bit not a coded one");

    // Preamble length
    a_pre_length: assert property (@(posedge clk) disable iff (rst)
        (s.st == FMTX_SFD && $past(s.st) == FMTX_PRE) |-> $past(s.cnt) == FMTX_PRE_LAST)
        else $error("preamble length wrong");

    // Preamble even bits are ones, second half true
    a_pre_pattern: assert property (@(posedge clk) disable iff (rst)
        (s.st == FMTX_PRE && s.ph && !s.cnt[0]) |=> (!line_out.en || line_out.data))
        else $error("preamble pattern wrong");

    // Bit cell period
    a_cell_period: assert property (@(posedge clk) disable iff (rst)
        (cell_end && s.st == FMTX_PRE) |-> ##20 cell_end)
        else $error("bit cell not 20 cycles");

    // Header ends after fourteen bytes
    a_hdr_count: assert property (@(posedge clk) disable iff (rst)
        (s.st == FMTX_DATA && $past(s.st) == FMTX_HDR) |-> $past(s.hidx) == FMTX_LEN_LO_IDX)
        else $error("header byte count wrong");

    // Data field length bounds
    a_data_bounds: assert property (@(posedge clk) disable iff (rst)
        (s.st == FMTX_CRC && $past(s.st) != FMTX_CRC)
        |-> (s.dcnt >= FMTX_DATA_MIN && s.dcnt <= FMTX_DATA_MAX))
        else $error("data field length out of range");

    // Padding only for short payloads, length kept
    a_pad_short: assert property (@(posedge clk) disable iff (rst)
        (s.st == FMTX_PAD) |-> (s.len < FMTX_DATA_MIN && s.dcnt < FMTX_DATA_MIN) ##1 $stable(s.len))
        else $error("padding on a long payload");

    // CRC is 32 bits
    a_crc_length: assert property (@(posedge clk) disable iff (rst)
        (s.st == FMTX_IDLE && $past(s.st) == FMTX_CRC) |-> $past(s.cnt) == FMTX_CRC_LAST)
        else $error("crc length wrong");

    // Jabber silences the driver and flags collision
    a_jabber_off: assert property (@(posedge clk) disable iff (rst)
        s.jab |=> (!line_out.en && status.collision))
        else $error("driver active during jabber");

endmodule

// *** hdl/fmtx_pkg.sv ***
// Constants and types of the transmit framer and Manchester encoder.
// Assumes one 200 MHz clock and a byte-wide feed from the network controller.
// Overview of operation
// - Frame opens with 62 alternating preamble bits
// - Two one bits follow as start delimiter
// - Six-byte destination, then six-byte source address
// - Two-byte length field holds true payload count
// - Data field spans 46 to 1500 bytes; the upper bound is not enforced, the length field sets it
// - Short payloads padded to 46, length unchanged
// - Four-byte CRC over addresses through data
// - Bits leave at 10 Mbit/s
// - NRZ bits merged with bit clock, Manchester
// - First half inverted, second half true data
// - Long transmission disables driver, holds off, flags
package fmtx_pkg;

    // Clock and line timing
    localparam int FMTX_CLK_PERIOD_NS = 5;
    localparam int FMTX_CLK_MHZ = 200;
    localparam int FMTX_BIT_RATE_MBPS = 10;
    localparam int FMTX_HALF_CELL = 1000 / (FMTX_BIT_RATE_MBPS * FMTX_CLK_PERIOD_NS * 2);
    localparam logic [3:0] FMTX_HALF_LAST = 4'(FMTX_HALF_CELL - 1);

    // Jabber watchdog times, in ms, and their cycle counts
    localparam int FMTX_JABBER_MS = 20;
    localparam int FMTX_HOLD_MS = 500;
    localparam int FMTX_JABBER_CYCLES = FMTX_JABBER_MS * FMTX_CLK_MHZ * 1000;
    localparam int FMTX_HOLD_CYCLES = FMTX_HOLD_MS * FMTX_CLK_MHZ * 1000;

    // Frame layout
    localparam logic [5:0] FMTX_PRE_LAST = 6'h3D;
    localparam logic [5:0] FMTX_SFD_LAST = 6'h01;
    localparam logic [3:0] FMTX_LEN_HI_IDX = 4'hC;
    localparam logic [3:0] FMTX_LEN_LO_IDX = 4'hD;
    localparam logic [10:0] FMTX_DATA_MIN = 11'h02E;
    localparam logic [10:0] FMTX_DATA_MAX = 11'h5DC;
    localparam logic [5:0] FMTX_CRC_LAST = 6'h1F;
    localparam logic [7:0] FMTX_PAD_BYTE = 8'h00;
    localparam logic [2:0] FMTX_BIT_LAST = 3'h7;

    // CRC-32, reflected form for LSB-first shifting
    localparam logic [31:0] FMTX_CRC_INIT = 32'hFFFFFFFF;
    localparam logic [31:0] FMTX_CRC_POLY = 32'hEDB88320;

    typedef enum logic [2:0] {
        FMTX_IDLE, FMTX_PRE, FMTX_SFD, FMTX_HDR, FMTX_DATA, FMTX_PAD, FMTX_CRC
    } fmtx_phase_type;

    // Line toward the transceiver
    typedef struct packed {
        logic en;
        logic data;
    } fmtx_line_type;

    // Status toward the controller
    typedef struct packed {
        logic collision;
        logic underrun;
        logic frame_done;
    } fmtx_stat_type;

    typedef struct packed {
        fmtx_phase_type st;
        logic [3:0] div;
        logic ph;
        logic [5:0] cnt;
        logic [2:0] bidx;
        logic [7:0] byte_v;
        logic [3:0] hidx;
        logic [7:0] len_hi;
        logic [10:0] len;
        logic [10:0] dcnt;
        logic [26:0] jcnt;
        logic jab;
        fmtx_line_type line;
        fmtx_stat_type stat;
    } fmtx_top_state_type;

    localparam fmtx_top_state_type FMTX_TOP_RST = '0;

endpackage

// *** hdl/fmtx_buf2.sv ***
// Two-entry byte buffer between the controller and the serializer.
// Assumes the draining side pops only while out_valid is high.
`timescale 1ns/10ps
module fmtx_buf2
    import fmtx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [7:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data
);

    typedef struct packed {
        logic [1:0][7:0] mem;
        logic wr;
        logic rd;
        logic [1:0] cnt;
    } fmtx_buf_state_type;

    fmtx_buf_state_type s, n;
    logic push;
    logic pop;

    // Full and empty straight from the occupancy count
    assign in_ready = (s.cnt != 2'h2);
    assign out_valid = (s.cnt != 2'h0);
    assign out_data = s.mem[s.rd];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Write and read pointers move independently
    always_comb begin
        n = s;
        if (push) begin
            n.mem[s.wr] = in_data;
            n.wr = ~s.wr;
        end
        if (pop) begin
            n.rd = ~s.rd;
        end
        n.cnt = s.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

endmodule

// *** hdl/fmtx_crc32.sv ***
// Bit-serial CRC-32 generator and drain shifter.
// Assumes one step per transmitted bit, least significant bit first.
`timescale 1ns/10ps
module fmtx_crc32
    import fmtx_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic init,
    input wire logic step,
    input wire logic bit_in,
    input wire logic drain,
    // Next check bit to send
    output logic crc_bit
);

    typedef struct packed {
        logic [31:0] crc;
    } fmtx_crc_state_type;

    fmtx_crc_state_type s, n;
    logic fb;

    // Check bits leave complemented, lowest first
    assign crc_bit = ~s.crc[0];
    assign fb = s.crc[0] ^ bit_in;

    // Reflected shift keeps bit order equal to the line order
    always_comb begin
        n = s;
        if (init) begin
            n.crc = FMTX_CRC_INIT;
        end else if (step) begin
            n.crc = {1'b0, s.crc[31:1]} ^ (fb ? FMTX_CRC_POLY : 32'h00000000);
        end else if (drain) begin
            n.crc = {1'b1, s.crc[31:1]};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s.crc <= FMTX_CRC_INIT;
        end else begin
            s <= n;
        end
    end

endmodule

// *** tb/fmtx_ctrl_model.sv ***
// Behavioural network controller that feeds frame bytes to the framer.
// Assumes the framer takes a byte at a rising edge with in_valid and in_ready high.
`timescale 1ns/10ps
module fmtx_ctrl_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Byte feed
    output logic in_valid,
    input wire logic in_ready,
    output logic [7:0] in_data
);
    // Idle feed, data shows no stale byte
    initial begin
        in_valid = 1'b0;
        in_data = 8'hFF;
    end

    // One byte at a time, held until taken, then gap idle cycles
    task automatic send(input logic [7:0] bytes[$], input int gap);
        int n;
        n = (bytes.size() > 1514) ? 1514 : bytes.size();
        @(posedge clk);
        #1;
        for (int i = 0; i < n; i++) begin
            in_valid = 1'b1;
            in_data = bytes[i];
            // Ready is settled here, so the next edge takes the byte
            while (in_ready !== 1'b1) begin
                @(posedge clk);
                #1;
            end
            @(posedge clk);
            #1;
            if (gap > 0) begin
                in_valid = 1'b0;
                in_data = ~bytes[i];
                repeat (gap) @(posedge clk);
                #1;
            end
        end
        in_valid = 1'b0;
        in_data = ~in_data;
    endtask
endmodule

// *** tb/fmtx_top_test.sv ***
// Self-checking bench of the transmit framer: decodes the Manchester line.
// Assumes the controller model drives the byte feed; jabber counts shortened.
`timescale 1ns/10ps
module fmtx_top_test;
    import fmtx_pkg::*;
    localparam int unsigned JAB = 34000;
    localparam int unsigned HOLD = 50;
    logic clk;
    logic rst;
    logic in_valid;
    logic in_ready;
    logic [7:0] in_data;
    fmtx_line_type line_out;
    fmtx_stat_type status;
    int failures = 0;
    int check_count = 0;
    int done_n = 0;
    int under_n = 0;
    int starts[$];
    logic samp[$];
    logic [7:0] fb[$];
    logic eb[$];
    logic en_p = 1'b0;
    logic full_seen = 1'b0;

    fmtx_top #(.JABBER_CYCLES(JAB), .HOLD_CYCLES(HOLD)) i_dut (.clk(clk), .rst(rst),
        .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
        .line_out(line_out), .status(status));
    fmtx_ctrl_model i_ctrl (.clk(clk), .rst(rst), .in_valid(in_valid),
        .in_ready(in_ready), .in_data(in_data));

    // 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Line monitor: registered outputs read before the edge updates land
    always @(posedge clk) begin
        if (line_out.en === 1'b1 && en_p !== 1'b1) starts.push_back(samp.size());
        if (line_out.en === 1'b1) samp.push_back(line_out.data);
        en_p = line_out.en;
        if (status.frame_done === 1'b1) done_n++;
        if (status.underrun === 1'b1) under_n++;
        if (in_ready === 1'b0) full_seen = 1'b1;
        // Skipped in reset: the line register is unknown before the first edge
        if (rst === 1'b0 && line_out.en !== 1'b1 && line_out.data !== 1'b0) begin
            failures++;
            $display("Error idle line data expected 0 seen %b", line_out.data);
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Builds the byte feed and the expected line bits of one frame
    task automatic mk(input int len);
        logic [31:0] crc;
        logic b;
        int dl;
        fb = {};
        eb = {};
        crc = FMTX_CRC_INIT;
        dl = (len < 46) ? 46 : len;
        for (int i = 0; i < 62; i++) eb.push_back(i % 2 == 0);
        eb.push_back(1'b1);
        eb.push_back(1'b1);
        for (int i = 0; i < 14 + len; i++) begin
            fb.push_back(i < 12 ? 8'(8'hA0 + i) : i == 12 ? 8'(len >> 8) :
                i == 13 ? 8'(len) : 8'(i * 7 + 3));
        end
        for (int i = 0; i < 14 + dl; i++) begin
            for (int k = 0; k < 8; k++) begin
                b = (i < fb.size()) ? fb[i][k] : FMTX_PAD_BYTE[k];
                eb.push_back(b);
                crc = (crc >> 1) ^ ((crc[0] ^ b) ? FMTX_CRC_POLY : 32'h00000000);
            end
        end
        for (int k = 0; k < 32; k++) eb.push_back(~crc[k]);
    endtask

    task automatic wait_done(input int n, input int lim);
        int t;
        t = 0;
        while (done_n < n && t < lim) begin
            @(posedge clk);
            t++;
        end
        chk("frame_done count", n, done_n);
        repeat (5) @(posedge clk);
    endtask

    // Mid-half samples: first half must be the inverse of the second
    task automatic chk_frame(input int idx, input logic e[$]);
        int s;
        int cells;
        int em;
        int eb_n;
        em = 0;
        eb_n = 0;
        chk("frame started", 1, idx < starts.size());
        if (idx < starts.size()) begin
            s = starts[idx];
            cells = ((idx + 1 < starts.size()) ? starts[idx + 1] : samp.size()) - s;
            cells = cells / 20;
            chk("bit cells", e.size(), cells);
            for (int k = 0; k < e.size() && k < cells; k++) begin
                if (samp[s + 20 * k + 5] !== ~samp[s + 20 * k + 15]) em++;
                if (samp[s + 20 * k + 15] !== e[k]) eb_n++;
            end
            chk("cells without mid transition", 0, em);
            chk("wrong line bits", 0, eb_n);
        end
    endtask

    // Short payload fed slowly: padding, true length, CRC
    task automatic t_short();
        mk(5);
        fork
            i_ctrl.send(fb, 40);
        join_none
        wait_done(1, 15000);
        chk_frame(0, eb);
        $display("test short payload done");
    endtask

    // Two frames back to back, buffer filled until it refuses
    task automatic t_pair();
        logic [7:0] q1[$];
        logic e1[$];
        mk(60);
        q1 = fb;
        e1 = eb;
        mk(46);
        q1 = {q1, fb};
        fork
            i_ctrl.send(q1, 0);
        join_none
        wait_done(3, 30000);
        chk_frame(1, e1);
        chk_frame(2, eb);
        chk("buffer refused", 1, full_seen);
        $display("test back to back done");
    endtask

    // Feed stops mid header: frame aborted, then resync by reset
    task automatic t_underrun();
        logic [7:0] q[$];
        int t;
        mk(20);
        q = fb[0:9];
        t = 0;
        i_ctrl.send(q, 0);
        while (under_n < 1 && t < 5000) begin
            @(posedge clk);
            t++;
        end
        repeat (3) @(posedge clk);
        chk("underrun pulses", 1, under_n);
        chk("line enable after abort", 0, line_out.en);
        chk("frame_done after abort", 3, done_n);
        #1 rst = 1'b1;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        chk("line after reset", 0, line_out);
        $display("test underrun done");
    endtask

    // Over-long frame: driver off with collision, held off after frame end
    task automatic t_jabber();
        int t;
        mk(220);
        t = 0;
        fork
            i_ctrl.send(fb, 0);
        join_none
        while (starts.size() < 5 && t < 3000) begin
            @(posedge clk);
            t++;
        end
        t = 0;
        while (status.collision !== 1'b1 && t < 40000) begin
            @(posedge clk);
            t++;
        end
        chk("jabber trip near limit", 1, t + 3 >= JAB && t <= JAB + 3);
        repeat (2) @(posedge clk);
        chk("driver off in jabber", 0, line_out.en);
        wait_done(4, 10000);
        t = 0;
        while (status.collision === 1'b1 && t < 200) begin
            @(posedge clk);
            t++;
        end
        chk("hold off near limit", 1, t + 8 >= HOLD && t <= HOLD + 3);
        $display("test jabber done");
    endtask

    // Zero length field: the whole data field is padding, length stays zero
    task automatic t_empty();
        mk(0);
        fork
            i_ctrl.send(fb, 0);
        join_none
        wait_done(5, 15000);
        chk_frame(5, eb);
        $display("test empty payload done");
    endtask

    // Watchdog past the expected run of about 91000 cycles, under the run budget
    initial begin
        repeat (97000) @(posedge clk);
        failures++;
        $display("Error watchdog expired before the tests ended");
        close_out();
    end

    initial begin
        rst = 1'b1;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        chk("line in reset", 0, line_out);
        chk("ready after reset", 1, in_ready);
        t_short();
        t_pair();
        t_underrun();
        t_jabber();
        t_empty();
        close_out();
    end
endmodule
